// file: dbg_aq_model.sv
// Behavioural model of the action-qualifier source and the time-base tick.
`default_nettype none

module dbg_aq_model #(
   parameter int TICK_DIV = 4
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic lvl_a,
   input  wire logic lvl_b,
   output var  logic timebase_tick,
   output var  logic channel_a_pwm,
   output var  logic channel_b_pwm
);
   timeunit 1ns;
   timeprecision 100ps;

   int unsigned div_cnt;

   // The tick runs free; the waveforms are registered like a real stage.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt       <= 0;
         timebase_tick <= 1'b0;
         channel_a_pwm <= 1'b0;
         channel_b_pwm <= 1'b0;
      end else begin
         div_cnt       <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
         timebase_tick <= (div_cnt == TICK_DIV - 1);
         channel_a_pwm <= lvl_a;
         channel_b_pwm <= lvl_b;
      end
   end

endmodule
`default_nettype wire

// file: dbg_dead_band.sv
// Dead-band generator top with its Wishbone register slave.
// Notes on behaviour
// - Inputs are the two action-qualifier waveforms.
// - Default source: channel A feeds both paths.
// - One setting: falling from A, rising from B.
// - One setting: rising from A, falling from B.
// - One setting: channel B feeds both paths.
// - Two bits choose which delays are applied.
// - Two bits invert each delayed signal independently.
// - No delay applied: plain pass-through, polarity ignored.
// - Both delays: polarity picks the four classical pairs.
// - Falling only: A undelayed, B falling-delayed from the channel feeding the falling path.
// - Rising only: A rising-delayed, B undelayed B.
// - Every setting combination is legal and supported.
// - Two ten-bit counts give delays in ticks.
`default_nettype none
`include "dbg_defs.svh"

module dbg_dead_band (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire dbg_pkg::dbg_wb_req_s  wb_req,
   output var  logic [`DBG_DAT_W-1:0] wb_dat_o,
   output var  logic                  wb_ack_o,
   input  wire logic                  timebase_tick,
   input  wire logic                  channel_a_pwm,
   input  wire logic                  channel_b_pwm,
   output var  logic                  dead_band_out_a,
   output var  logic                  dead_band_out_b
);

   dbg_pkg::dbg_ctrl_s      dead_band_control;
   dbg_pkg::dbg_ctrl_s      next_dead_band_control;
   logic [`DBG_DELAY_W-1:0] rising_edge_delay_count;
   logic [`DBG_DELAY_W-1:0] next_rising_edge_delay_count;
   logic [`DBG_DELAY_W-1:0] falling_edge_delay_count;
   logic [`DBG_DELAY_W-1:0] next_falling_edge_delay_count;
   logic [`DBG_DAT_W-1:0]   next_wb_dat_o;
   logic                    next_wb_ack_o;
   logic                    next_out_a;
   logic                    next_out_b;
   logic                    bus_take;
   logic [`DBG_IDX_W-1:0]   bus_index;
   logic                    rise_src;
   logic                    fall_src;
   logic                    rising_edge_delay;
   logic                    falling_edge_delay;
   logic                    rise_shaped;
   logic                    fall_shaped;
   logic [`DBG_STATUS_W-1:0] status_word;

   // Merges write data into a 16-bit register under the byte enables.
   function automatic logic [15:0] merge_half(
      input logic [15:0] old_value,
      input logic [31:0] wr_data,
      input logic [3:0]  wr_sel
   );
      logic [15:0] result;
      result = old_value;
      if (wr_sel[0]) begin
         result[7:0] = wr_data[7:0];
      end
      if (wr_sel[1]) begin
         result[15:8] = wr_data[15:8];
      end
      return result;
   endfunction

   // A request is taken once; ack drops in the cycle after it is given.
   assign bus_take  = wb_req.cyc && wb_req.stb && !wb_ack_o;
   assign bus_index = wb_req.adr[`DBG_ADR_W-1:2];

   // Register writes and registered read data for the bus slave.
   always_comb begin
      logic [15:0] merged;
      merged                        = 16'h0000;
      next_dead_band_control        = dead_band_control;
      next_rising_edge_delay_count  = rising_edge_delay_count;
      next_falling_edge_delay_count = falling_edge_delay_count;
      next_wb_ack_o                 = bus_take;
      next_wb_dat_o                 = `DBG_DAT_RST;
      if (bus_take && wb_req.we) begin
         unique case (bus_index)
            `DBG_IDX_CONTROL: begin
               merged = merge_half({10'h000, dead_band_control},
                                   wb_req.dat, wb_req.sel);
               next_dead_band_control = merged[`DBG_CTRL_W-1:0];
            end
            `DBG_IDX_RISE_COUNT: begin
               merged = merge_half({6'h00, rising_edge_delay_count},
                                   wb_req.dat, wb_req.sel);
               next_rising_edge_delay_count = merged[`DBG_DELAY_W-1:0];
            end
            `DBG_IDX_FALL_COUNT: begin
               merged = merge_half({6'h00, falling_edge_delay_count},
                                   wb_req.dat, wb_req.sel);
               next_falling_edge_delay_count = merged[`DBG_DELAY_W-1:0];
            end
            default: begin
               merged = 16'h0000; // Status and unmapped writes are ignored.
            end
         endcase
      end else if (bus_take) begin
         unique case (bus_index)
            `DBG_IDX_CONTROL: begin
               next_wb_dat_o = {26'h0000000, dead_band_control};
            end
            `DBG_IDX_RISE_COUNT: begin
               next_wb_dat_o = {22'h000000, rising_edge_delay_count};
            end
            `DBG_IDX_FALL_COUNT: begin
               next_wb_dat_o = {22'h000000, falling_edge_delay_count};
            end
            `DBG_IDX_STATUS: begin
               next_wb_dat_o = {28'h0000000, status_word};
            end
            default: begin
               next_wb_dat_o = `DBG_DAT_RST;
            end
         endcase
      end
   end

   // Registers of the bus slave; the control reset selects A for both.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dead_band_control        <= `DBG_CONTROL_RST;
         rising_edge_delay_count  <= `DBG_DELAY_RST;
         falling_edge_delay_count <= `DBG_DELAY_RST;
         wb_ack_o                 <= 1'b0;
         wb_dat_o                 <= `DBG_DAT_RST;
      end else begin
         dead_band_control        <= next_dead_band_control;
         rising_edge_delay_count  <= next_rising_edge_delay_count;
         falling_edge_delay_count <= next_falling_edge_delay_count;
         wb_ack_o                 <= next_wb_ack_o;
         wb_dat_o                 <= next_wb_dat_o;
      end
   end

   // Each delay path picks its own source from the two waveforms.
   assign rise_src = dead_band_control.in_mode[`DBG_IN_RISE_FROM_B] ?
                     channel_b_pwm : channel_a_pwm;
   assign fall_src = dead_band_control.in_mode[`DBG_IN_FALL_FROM_B] ?
                     channel_b_pwm : channel_a_pwm;

   // Rising-edge delay path.
   dbg_edge_delay #(
      .DELAY_RISING (1'b1)
   ) u_rise (
      .clk           (clk),
      .rst_n         (rst_n),
      .timebase_tick (timebase_tick),
      .delay_count   (rising_edge_delay_count),
      .edge_in       (rise_src),
      .edge_out      (rising_edge_delay)
   );

   // Falling-edge delay path.
   dbg_edge_delay #(
      .DELAY_RISING (1'b0)
   ) u_fall (
      .clk           (clk),
      .rst_n         (rst_n),
      .timebase_tick (timebase_tick),
      .delay_count   (falling_edge_delay_count),
      .edge_in       (fall_src),
      .edge_out      (falling_edge_delay)
   );

   // Polarity applies to the delayed signals only.
   assign rise_shaped = rising_edge_delay ^
      dead_band_control.polarity_select[`DBG_POL_RISE_INV];
   assign fall_shaped = falling_edge_delay ^
      dead_band_control.polarity_select[`DBG_POL_FALL_INV];

   // Output A takes the rising path when applied, else raw channel A;
   // output B takes the falling path when applied, else raw channel B.
   always_comb begin
      next_out_a = channel_a_pwm;
      next_out_b = channel_b_pwm;
      if (dead_band_control.delay_apply[`DBG_APPLY_RISE]) begin
         next_out_a = rise_shaped;
      end
      if (dead_band_control.delay_apply[`DBG_APPLY_FALL]) begin
         next_out_b = fall_shaped;
      end
   end

   // Output flops.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dead_band_out_a <= 1'b0;
         dead_band_out_b <= 1'b0;
      end else begin
         dead_band_out_a <= next_out_a;
         dead_band_out_b <= next_out_b;
      end
   end

   // Live state shown in the status register.
   assign status_word = {dead_band_out_b, dead_band_out_a,
                         falling_edge_delay, rising_edge_delay};

   // Checks on the bus slave.
   bus_ack_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack stood for more than one cycle");

   bus_ack_timely_a: assert property (@(posedge clk) disable iff (!rst_n)
      (wb_req.cyc && wb_req.stb && !wb_ack_o) |=> wb_ack_o)
      else $error("request was not acknowledged in one cycle");

   reg_write_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
      (bus_take && wb_req.we && bus_index == `DBG_IDX_RISE_COUNT &&
       wb_req.sel[1:0] == 2'h3) |=>
      rising_edge_delay_count == $past(wb_req.dat[`DBG_DELAY_W-1:0]))
      else $error("rising delay count did not take written value");

   // Checks on source selection.
   rise_src_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      rise_src == (dead_band_control.in_mode[0] ? channel_b_pwm
                                                : channel_a_pwm))
      else $error("rising path fed from wrong channel");

   fall_src_sel_a: assert property (@(posedge clk) disable iff (!rst_n)
      fall_src == (dead_band_control.in_mode[1] ? channel_b_pwm
                                                : channel_a_pwm))
      else $error("falling path fed from wrong channel");

   // Checks on output modes.
   bypass_pass_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dead_band_control.delay_apply == 2'h0 &&
       $stable(dead_band_control)) |=>
      (dead_band_out_a == $past(channel_a_pwm) &&
       dead_band_out_b == $past(channel_b_pwm)))
      else $error("bypass did not pass inputs through");

   comp_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dead_band_control.delay_apply == 2'h3 &&
       dead_band_control.polarity_select == 2'h2) |=>
      (dead_band_out_a == $past(rising_edge_delay) &&
       dead_band_out_b == !$past(falling_edge_delay)))
      else $error("active high complementary pair wrong");

   fall_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dead_band_control.delay_apply == 2'h1) |=>
      (dead_band_out_a == $past(channel_a_pwm) &&
       dead_band_out_b == $past(fall_shaped)))
      else $error("falling-only mode wrong");

   rise_only_a: assert property (@(posedge clk) disable iff (!rst_n)
      (dead_band_control.delay_apply == 2'h2) |=>
      (dead_band_out_a == $past(rise_shaped) &&
       dead_band_out_b == $past(channel_b_pwm)))
      else $error("rising-only mode wrong");

   // Checks on the delay paths.
   rise_held_a: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(rising_edge_delay) && rising_edge_delay_count != 10'h000) |->
      ($past(rise_src, 1) && $past(rise_src, 2)))
      else $error("rising edge passed without a held input");

   fall_rise_fast_a: assert property (@(posedge clk) disable iff (!rst_n)
      (fall_src && !falling_edge_delay) |=> falling_edge_delay)
      else $error("falling path held back a rising edge");

   // Main scenarios.
   bypass_c: cover property (@(posedge clk) disable iff (!rst_n)
      dead_band_control.delay_apply == 2'h0 && $rose(dead_band_out_a));
   comp_high_c: cover property (@(posedge clk) disable iff (!rst_n)
      dead_band_control.delay_apply == 2'h3 && $rose(dead_band_out_b));
   rise_delay_c: cover property (@(posedge clk) disable iff (!rst_n)
      $rose(rising_edge_delay) && rising_edge_delay_count > 10'h002);
   absorb_c: cover property (@(posedge clk) disable iff (!rst_n)
      rise_src ##1 !rise_src && !rising_edge_delay);

endmodule
`default_nettype wire

// file: dbg_dead_band_tb.sv
// Self-checking testbench of the dead-band generator.
`default_nettype none
`include "dbg_defs.svh"

`define DBG_CHK(got, exp) \
   begin \
      tests_run++; \
      if ((got) !== (exp)) begin \
         err_count++; \
         $display("CHECK FAILED at %0t: got %0h expected %0h", \
                  $time, got, exp); \
      end \
   end

module dbg_dead_band_tb;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int LIMIT = 20000;

   logic                  clk;
   logic                  rst_n;
   dbg_pkg::dbg_wb_req_s  wb_req;
   logic [`DBG_DAT_W-1:0] wb_dat_o;
   logic                  wb_ack_o;
   logic                  timebase_tick;
   logic                  channel_a_pwm;
   logic                  channel_b_pwm;
   logic                  dead_band_out_a;
   logic                  dead_band_out_b;
   logic                  lvl_a;
   logic                  lvl_b;
   int                    err_count;
   int                    tests_run;
   int                    cycles;
   logic [31:0]           rd;

   dbg_dead_band dbg_dead_band_inst (
      .clk             (clk),
      .rst_n           (rst_n),
      .wb_req          (wb_req),
      .wb_dat_o        (wb_dat_o),
      .wb_ack_o        (wb_ack_o),
      .timebase_tick   (timebase_tick),
      .channel_a_pwm   (channel_a_pwm),
      .channel_b_pwm   (channel_b_pwm),
      .dead_band_out_a (dead_band_out_a),
      .dead_band_out_b (dead_band_out_b)
   );

   dbg_aq_model #(.TICK_DIV(4)) dbg_aq_model_inst (
      .clk           (clk),
      .rst_n         (rst_n),
      .lvl_a         (lvl_a),
      .lvl_b         (lvl_b),
      .timebase_tick (timebase_tick),
      .channel_a_pwm (channel_a_pwm),
      .channel_b_pwm (channel_b_pwm)
   );

   // Clock of 5 ns period.
   always #2.5 clk = ~clk;

   // Prints the counts and the verdict, then ends the run.
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         err_count++;
         end_sim();
      end
   end

   // One classic Wishbone cycle; waits for ack, then releases the bus.
   task automatic wb_cycle(input logic we, input logic [5:0] idx,
                           input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                  sel: 4'hF, dat: d};
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20)
         err_count++;
      q = wb_dat_o;
      wb_req <= '0;
      @(posedge clk);
      `DBG_CHK(wb_ack_o, 1'b0)
   endtask

   // Expected output pair for steady input levels.
   function automatic logic [1:0] exp_out(input logic [5:0] c,
                                          input logic a, input logic b);
      logic ra;
      logic fa;
      ra = c[4] ? b : a;
      fa = c[5] ? b : a;
      return {c[1] ? ra ^ c[2] : a, c[0] ? fa ^ c[3] : b};
   endfunction

   // Reset values, field widths and an unmapped place.
   task automatic test_regs();
      wb_cycle(1'b0, `DBG_IDX_CONTROL, 32'h0, rd);
      `DBG_CHK(rd, 32'h0000_0000)
      wb_cycle(1'b0, `DBG_IDX_RISE_COUNT, 32'h0, rd);
      `DBG_CHK(rd, 32'h0000_0000)
      wb_cycle(1'b1, `DBG_IDX_RISE_COUNT, 32'h0000_FFFF, rd);
      wb_cycle(1'b0, `DBG_IDX_RISE_COUNT, 32'h0, rd);
      `DBG_CHK(rd, 32'h0000_03FF)
      wb_cycle(1'b1, `DBG_IDX_FALL_COUNT, 32'h0000_0155, rd);
      wb_cycle(1'b0, `DBG_IDX_FALL_COUNT, 32'h0, rd);
      `DBG_CHK(rd, 32'h0000_0155)
      wb_cycle(1'b1, `DBG_IDX_CONTROL, 32'h0000_00FF, rd);
      wb_cycle(1'b0, `DBG_IDX_CONTROL, 32'h0, rd);
      `DBG_CHK(rd, 32'h0000_003F)
      wb_cycle(1'b1, 6'h20, 32'h0000_1234, rd);
      wb_cycle(1'b0, 6'h20, 32'h0, rd);
      `DBG_CHK(rd, 32'h0000_0000)
   endtask

   // Every control setting against every pair of steady input levels.
   task automatic test_modes();
      logic [1:0] v;
      wb_cycle(1'b1, `DBG_IDX_RISE_COUNT, 32'h0000_0001, rd);
      wb_cycle(1'b1, `DBG_IDX_FALL_COUNT, 32'h0000_0001, rd);
      for (int c = 0; c < 64; c++) begin
         wb_cycle(1'b1, `DBG_IDX_CONTROL, 32'(c), rd);
         for (int i = 0; i < 4; i++) begin
            v = 2'(i);
            @(posedge clk);
            lvl_a <= v[1];
            lvl_b <= v[0];
            repeat (16) @(posedge clk);
            `DBG_CHK({dead_band_out_a, dead_band_out_b}, exp_out(6'(c), v[1], v[0]))
         end
      end
   endtask

   // Complementary pair with three-tick delays on both edges.
   task automatic test_edges();
      wb_cycle(1'b1, `DBG_IDX_RISE_COUNT, 32'h0000_0003, rd);
      wb_cycle(1'b1, `DBG_IDX_FALL_COUNT, 32'h0000_0003, rd);
      wb_cycle(1'b1, `DBG_IDX_CONTROL, 32'h0000_000B, rd);
      lvl_a <= 1'b0;
      repeat (20) @(posedge clk);
      lvl_a <= 1'b1;
      repeat (6) @(posedge clk);
      `DBG_CHK({dead_band_out_a, dead_band_out_b}, 2'b00)
      repeat (19) @(posedge clk);
      `DBG_CHK({dead_band_out_a, dead_band_out_b}, 2'b10)
      lvl_a <= 1'b0;
      repeat (6) @(posedge clk);
      `DBG_CHK({dead_band_out_a, dead_band_out_b}, 2'b00)
      repeat (19) @(posedge clk);
      `DBG_CHK({dead_band_out_a, dead_band_out_b}, 2'b01)
   endtask

   // A pulse shorter than the rising delay never reaches output A.
   task automatic test_absorb();
      wb_cycle(1'b1, `DBG_IDX_CONTROL, 32'h0000_0003, rd);
      repeat (20) @(posedge clk);
      lvl_a <= 1'b1;
      repeat (2) @(posedge clk);
      lvl_a <= 1'b0;
      repeat (30) begin
         @(posedge clk);
         `DBG_CHK(dead_band_out_a, 1'b0)
      end
   endtask

   // Main sequence: reset, then each scenario in turn.
   initial begin
      clk       = 1'b0;
      rst_n     = 1'b0;
      wb_req    = '0;
      lvl_a     = 1'b0;
      lvl_b     = 1'b0;
      err_count = 0;
      tests_run = 0;
      cycles    = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      `DBG_CHK({wb_ack_o, dead_band_out_a, dead_band_out_b}, 3'b000)
      test_regs();
      test_modes();
      test_edges();
      test_absorb();
      end_sim();
   end

endmodule
`default_nettype wire

// file: dbg_defs.svh
// Offsets, field positions and reset values of the dead-band generator.
`ifndef DBG_DEFS_SVH
`define DBG_DEFS_SVH

// Register indices; the byte address is four times the index.
`define DBG_IDX_W             6
`define DBG_IDX_CONTROL       6'h0F
`define DBG_IDX_RISE_COUNT    6'h10
`define DBG_IDX_FALL_COUNT    6'h11
`define DBG_IDX_STATUS        6'h12

// Bus widths.
`define DBG_ADR_W             8
`define DBG_DAT_W             32
`define DBG_SEL_W             4

// Widths of the fields and of the delay counts.
`define DBG_CTRL_W            6
`define DBG_DELAY_W           10
`define DBG_STATUS_W          4

// Bit positions inside each two-bit control field.
`define DBG_IN_RISE_FROM_B    0
`define DBG_IN_FALL_FROM_B    1
`define DBG_POL_RISE_INV      0
`define DBG_POL_FALL_INV      1
`define DBG_APPLY_FALL        0
`define DBG_APPLY_RISE        1

// Reset values.
`define DBG_CONTROL_RST       6'h00
`define DBG_DELAY_RST         10'h000
`define DBG_DAT_RST           32'h0000_0000

`endif

// file: dbg_edge_delay.sv
// One edge delay path that holds back either rising or falling edges.
`default_nettype none
`include "dbg_defs.svh"

module dbg_edge_delay #(
   parameter bit DELAY_RISING = 1'b1
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    timebase_tick,
   input  wire logic [`DBG_DELAY_W-1:0] delay_count,
   input  wire logic                    edge_in,
   output var  logic                    edge_out
);

   logic [`DBG_DELAY_W-1:0] tick_count;
   logic [`DBG_DELAY_W-1:0] next_tick_count;
   logic                    next_edge_out;
   logic                    delayed_edge;

   // The edge this path holds back is the one towards DELAY_RISING.
   assign delayed_edge = (edge_in == DELAY_RISING);

   // A pending edge is dropped as soon as the input returns, so pulses
   // shorter than the delay never reach the output.
   always_comb begin
      next_edge_out   = edge_out;
      next_tick_count = `DBG_DELAY_RST;
      if (edge_in != edge_out) begin
         if (!delayed_edge) begin
            next_edge_out = edge_in;
         end else if (tick_count >= delay_count) begin
            next_edge_out = edge_in;
         end else if (timebase_tick) begin
            next_tick_count = tick_count + 10'h001;
         end else begin
            next_tick_count = tick_count;
         end
      end
   end

   // Registers the output level and the tick count.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         edge_out   <= 1'b0;
         tick_count <= `DBG_DELAY_RST;
      end else begin
         edge_out   <= next_edge_out;
         tick_count <= next_tick_count;
      end
   end

endmodule
`default_nettype wire

// file: dbg_pkg.sv
// Types shared by the dead-band generator files.
`default_nettype none
package dbg_pkg;

   // Classic Wishbone request as driven by the bus master.
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } dbg_wb_req_s;

   // Control register layout, most significant field first.
   typedef struct packed {
      logic [1:0] in_mode;
      logic [1:0] polarity_select;
      logic [1:0] delay_apply;
   } dbg_ctrl_s;

endpackage
`default_nettype wire
